/* File: hdl/irq_sense_and_sleep_control.sv */
// Interrupt sensing, vectoring, return stack and sleep control.
// Assumes the core sequencer signals instruction boundaries, sleep and
// return instructions as one-cycle pulses, and the timer its overflow.
`timescale 1ns/1ns
module irq_sense_and_sleep_control
    import irq_ctrl_pkg::*;
#(
    parameter int PC_WIDTH = 9
)
(
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    // AXI4-Lite slave
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Core sequencer side
    input wire logic INSTR_BOUNDARY_IN,
    input wire logic SLEEP_INSTR_IN,
    input wire logic RETURN_FROM_IRQ_IN,
    input wire logic CALL_IN,
    input wire logic RET_IN,
    input wire logic SET_GLOBAL_IN,
    input wire logic CLEAR_GLOBAL_IN,
    input wire logic [PC_WIDTH-1:0] PC_IN,
    output logic [PC_WIDTH-1:0] VECTOR_ADDR_OUT,
    output logic VECTOR_FETCH_OUT,
    output logic [PC_WIDTH-1:0] RETURN_ADDR_OUT,
    output logic RETURN_LOAD_OUT,
    output logic CORE_STALL_OUT,
    output logic OSC_STOP_OUT,
    output logic GLOBAL_ENABLE_OUT,
    // Event side
    input wire logic EXTERNAL_REQUEST_LINE_IN,
    input wire logic TIMER_OVERFLOW_IN
);

    typedef struct packed
    {
        logic awready;
        logic wready;
        logic aw_seen;
        logic w_seen;
        logic [7:0] aw_addr;
        logic [7:0] w_data;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] core_control;
        logic ext_enable;
        logic ovf_enable;
        logic ovf_flag;
        logic global_enable;
        logic pin_sample;
        logic pin_prev;
        logic edge_flag;
        core_state_t state;
        logic [1:0] seq_cnt;
        logic serving_ext;
        logic hold_one;
        logic [PC_WIDTH-1:0] stack0;
        logic [PC_WIDTH-1:0] stack1;
        logic [PC_WIDTH-1:0] stack2;
        logic [1:0] depth;
        logic [PC_WIDTH-1:0] vector_addr;
        logic vector_fetch;
        logic [PC_WIDTH-1:0] return_addr;
        logic return_load;
        logic stall;
        logic osc_stop;
    } ctrl_t;

    ctrl_t cur_q;
    ctrl_t nxt_d;

    logic [1:0] sense;
    logic level_req;
    logic ext_req;
    logic ovf_req;
    logic any_req;
    logic ovf_set;
    logic wr_fire;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] rd_byte;
    logic rd_hit;

    // Request qualification from current state
    always_comb
    begin
        sense = cur_q.core_control[SENSE_HIGH_BIT:SENSE_LOW_BIT];
        level_req = (sense == SENSE_LOW) && !cur_q.pin_sample;
        ext_req = cur_q.ext_enable && cur_q.global_enable
            && (level_req || (sense[1] && cur_q.edge_flag));
        ovf_req = cur_q.ovf_enable && cur_q.global_enable
            && cur_q.ovf_flag;
        any_req = ext_req || ovf_req;
        ovf_set = TIMER_OVERFLOW_IN && !cur_q.osc_stop;
    end

    // Register read mux; reserved bits are zero
    always_comb
    begin
        rd_hit = 1'b1;
        case (S_AXI_ARADDR_IN)
            CORE_CONTROL_ADDR:
                rd_byte = cur_q.core_control & CORE_CONTROL_MASK;
            EXT_IRQ_MASK_ADDR:
                rd_byte = {1'b0, cur_q.ext_enable, 6'h00};
            TIMER_IRQ_MASK_ADDR:
                rd_byte = {6'h00, cur_q.ovf_enable, 1'b0};
            TIMER_IRQ_FLAGS_ADDR:
                rd_byte = {6'h00, cur_q.ovf_flag, 1'b0};
            STATUS_WORD_ADDR:
                rd_byte = {cur_q.global_enable, 7'h00};
            CORE_STATE_ADDR:
                rd_byte = {3'h0, cur_q.state, cur_q.depth};
            default:
            begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Next-state logic for the whole block
    always_comb
    begin
        nxt_d = cur_q;
        nxt_d.vector_fetch = 1'b0;
        nxt_d.return_load = 1'b0;

        // Write channel: address and data in either order
        if (S_AXI_AWVALID_IN && cur_q.awready)
        begin
            nxt_d.aw_seen = 1'b1;
            nxt_d.aw_addr = S_AXI_AWADDR_IN;
            nxt_d.awready = 1'b0;
        end
        if (S_AXI_WVALID_IN && cur_q.wready)
        begin
            nxt_d.w_seen = 1'b1;
            nxt_d.w_data = S_AXI_WDATA_IN[7:0];
            nxt_d.w_lane = S_AXI_WSTRB_IN[0];
            nxt_d.wready = 1'b0;
        end
        wr_fire = cur_q.aw_seen && cur_q.w_seen && !cur_q.bvalid;
        wa = cur_q.aw_addr;
        wd = cur_q.w_data;
        if (wr_fire)
        begin
            nxt_d.aw_seen = 1'b0;
            nxt_d.w_seen = 1'b0;
            nxt_d.bvalid = 1'b1;
            nxt_d.bresp = RESP_OKAY;
            if (cur_q.w_lane)
            begin
                case (wa)
                    CORE_CONTROL_ADDR:
                        nxt_d.core_control = wd & CORE_CONTROL_MASK;
                    EXT_IRQ_MASK_ADDR:
                        nxt_d.ext_enable = wd[EXT_ENABLE_BIT];
                    TIMER_IRQ_MASK_ADDR:
                        nxt_d.ovf_enable = wd[OVF_ENABLE_BIT];
                    TIMER_IRQ_FLAGS_ADDR:
                        if (wd[OVF_FLAG_BIT])
                        begin
                            nxt_d.ovf_flag = 1'b0;
                        end
                    STATUS_WORD_ADDR:
                        nxt_d.global_enable = wd[GLOBAL_ENABLE_BIT];
                    CORE_STATE_ADDR:
                        nxt_d.bresp = RESP_OKAY;
                    default:
                        nxt_d.bresp = RESP_SLVERR;
                endcase
            end
        end
        if (cur_q.bvalid && S_AXI_BREADY_IN)
        begin
            nxt_d.bvalid = 1'b0;
            nxt_d.awready = 1'b1;
            nxt_d.wready = 1'b1;
        end

        // Read channel
        if (S_AXI_ARVALID_IN && cur_q.arready)
        begin
            nxt_d.arready = 1'b0;
            nxt_d.rvalid = 1'b1;
            nxt_d.rdata = {24'h000000, rd_byte};
            nxt_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (cur_q.rvalid && S_AXI_RREADY_IN)
        begin
            nxt_d.rvalid = 1'b0;
            nxt_d.arready = 1'b1;
        end

        // Core status word updates
        if (SET_GLOBAL_IN)
        begin
            nxt_d.global_enable = 1'b1;
        end
        if (CLEAR_GLOBAL_IN)
        begin
            nxt_d.global_enable = 1'b0;
        end

        // Pin sampling and edge capture; output drive is ignored
        nxt_d.pin_sample = EXTERNAL_REQUEST_LINE_IN;
        nxt_d.pin_prev = cur_q.pin_sample;
        if (sense == SENSE_LOW || sense == 2'b01)
        begin
            nxt_d.edge_flag = 1'b0;
        end

        // Sequencer: run, entry, return and sleep states
        case (cur_q.state)
            ST_RUN:
            begin
                nxt_d.stall = 1'b0;
                if (INSTR_BOUNDARY_IN && any_req
                    && !cur_q.hold_one)
                begin
                    nxt_d.state = ST_ENTRY;
                    nxt_d.stall = 1'b1;
                    nxt_d.seq_cnt = 2'd0;
                    nxt_d.global_enable = 1'b0;
                    nxt_d.serving_ext = ext_req;
                    nxt_d.stack2 = cur_q.stack1;
                    nxt_d.stack1 = cur_q.stack0;
                    nxt_d.stack0 = PC_IN;
                    if (cur_q.depth != 2'(STACK_DEPTH))
                    begin
                        nxt_d.depth = cur_q.depth + 2'd1;
                    end
                end
                else if (RETURN_FROM_IRQ_IN)
                begin
                    nxt_d.state = ST_RETURN;
                    nxt_d.stall = 1'b1;
                    nxt_d.seq_cnt = 2'd0;
                end
                else if (SLEEP_INSTR_IN
                    && cur_q.core_control[SLEEP_ARM_BIT])
                begin
                    nxt_d.stall = 1'b1;
                    if (cur_q.core_control[SLEEP_DEPTH_BIT])
                    begin
                        nxt_d.state = ST_POWER_DOWN;
                        nxt_d.osc_stop = 1'b1;
                    end
                    else
                    begin
                        nxt_d.state = ST_IDLE;
                    end
                end
                else
                begin
                    if (CALL_IN)
                    begin
                        nxt_d.stack2 = cur_q.stack1;
                        nxt_d.stack1 = cur_q.stack0;
                        nxt_d.stack0 = PC_IN;
                        if (cur_q.depth != 2'(STACK_DEPTH))
                        begin
                            nxt_d.depth = cur_q.depth + 2'd1;
                        end
                    end
                    else if (RET_IN)
                    begin
                        nxt_d.return_addr = cur_q.stack0;
                        nxt_d.return_load = 1'b1;
                        nxt_d.stack0 = cur_q.stack1;
                        nxt_d.stack1 = cur_q.stack2;
                        if (cur_q.depth != 2'd0)
                        begin
                            nxt_d.depth = cur_q.depth - 2'd1;
                        end
                    end
                    if (INSTR_BOUNDARY_IN)
                    begin
                        nxt_d.hold_one = 1'b0;
                    end
                end
            end
            ST_ENTRY:
            begin
                nxt_d.seq_cnt = cur_q.seq_cnt + 2'd1;
                if (cur_q.seq_cnt == SEQ_LAST)
                begin
                    nxt_d.state = ST_RUN;
                    nxt_d.stall = 1'b0;
                    nxt_d.vector_fetch = 1'b1;
                    if (cur_q.serving_ext)
                    begin
                        nxt_d.vector_addr = EXT_VECTOR_ADDR;
                        nxt_d.edge_flag = 1'b0;
                    end
                    else
                    begin
                        nxt_d.vector_addr = OVF_VECTOR_ADDR;
                        nxt_d.ovf_flag = 1'b0;
                    end
                end
            end
            ST_RETURN:
            begin
                nxt_d.seq_cnt = cur_q.seq_cnt + 2'd1;
                if (cur_q.seq_cnt == SEQ_LAST)
                begin
                    nxt_d.state = ST_RUN;
                    nxt_d.stall = 1'b0;
                    nxt_d.global_enable = 1'b1;
                    nxt_d.hold_one = 1'b1;
                    nxt_d.return_addr = cur_q.stack0;
                    nxt_d.return_load = 1'b1;
                    nxt_d.stack0 = cur_q.stack1;
                    nxt_d.stack1 = cur_q.stack2;
                    if (cur_q.depth != 2'd0)
                    begin
                        nxt_d.depth = cur_q.depth - 2'd1;
                    end
                end
            end
            ST_IDLE:
            begin
                if (any_req)
                begin
                    nxt_d.state = ST_RUN;
                    nxt_d.stall = 1'b0;
                end
            end
            ST_POWER_DOWN:
            begin
                if (ext_req && level_req)
                begin
                    nxt_d.state = ST_RUN;
                    nxt_d.stall = 1'b0;
                    nxt_d.osc_stop = 1'b0;
                end
            end
            default:
                nxt_d.state = ST_RUN;
        endcase

        // Hardware set wins over every clear
        if (ovf_set)
        begin
            nxt_d.ovf_flag = 1'b1;
        end
        if ((sense == SENSE_FALL && cur_q.pin_prev
                && !cur_q.pin_sample)
            || (sense == SENSE_RISE && !cur_q.pin_prev
                && cur_q.pin_sample))
        begin
            nxt_d.edge_flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            cur_q <= '0;
            cur_q.awready <= 1'b1;
            cur_q.wready <= 1'b1;
            cur_q.arready <= 1'b1;
            cur_q.pin_sample <= 1'b1;
            cur_q.pin_prev <= 1'b1;
            cur_q.state <= ST_RUN;
        end
        else
        begin
            cur_q <= nxt_d;
        end
    end

    // Outputs straight from the state register
    assign S_AXI_AWREADY_OUT = cur_q.awready;
    assign S_AXI_WREADY_OUT = cur_q.wready;
    assign S_AXI_BRESP_OUT = cur_q.bresp;
    assign S_AXI_BVALID_OUT = cur_q.bvalid;
    assign S_AXI_ARREADY_OUT = cur_q.arready;
    assign S_AXI_RDATA_OUT = cur_q.rdata;
    assign S_AXI_RRESP_OUT = cur_q.rresp;
    assign S_AXI_RVALID_OUT = cur_q.rvalid;
    assign VECTOR_ADDR_OUT = cur_q.vector_addr;
    assign VECTOR_FETCH_OUT = cur_q.vector_fetch;
    assign RETURN_ADDR_OUT = cur_q.return_addr;
    assign RETURN_LOAD_OUT = cur_q.return_load;
    assign CORE_STALL_OUT = cur_q.stall;
    assign OSC_STOP_OUT = cur_q.osc_stop;
    assign GLOBAL_ENABLE_OUT = cur_q.global_enable;

endmodule : irq_sense_and_sleep_control

/* File: include/irq_ctrl_pkg.sv */
// Constants, register map and types for the interrupt and sleep controller.
// Assumes an AXI4-Lite master with 32-bit data; all registers are 8 bits.
package irq_ctrl_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] CORE_CONTROL_INDEX = 8'h35;
    localparam logic [7:0] EXT_IRQ_MASK_INDEX = 8'h3b;
    localparam logic [7:0] TIMER_IRQ_MASK_INDEX = 8'h39;

    // Byte addresses of the registers on the bus
    localparam logic [7:0] CORE_CONTROL_ADDR = 8'(CORE_CONTROL_INDEX * 4);
    localparam logic [7:0] EXT_IRQ_MASK_ADDR = 8'(EXT_IRQ_MASK_INDEX * 4);
    localparam logic [7:0] TIMER_IRQ_MASK_ADDR = 8'(TIMER_IRQ_MASK_INDEX * 4);
    localparam logic [7:0] TIMER_IRQ_FLAGS_ADDR = 8'h0c;
    localparam logic [7:0] STATUS_WORD_ADDR = 8'h10;
    localparam logic [7:0] CORE_STATE_ADDR = 8'h14;

    // Field positions
    localparam int SENSE_LOW_BIT = 0;
    localparam int SENSE_HIGH_BIT = 1;
    localparam int SLEEP_DEPTH_BIT = 4;
    localparam int SLEEP_ARM_BIT = 5;
    localparam int EXT_ENABLE_BIT = 6;
    localparam int OVF_ENABLE_BIT = 1;
    localparam int OVF_FLAG_BIT = 1;
    localparam int GLOBAL_ENABLE_BIT = 7;

    // Writable bit masks; the rest read as zero
    localparam logic [7:0] CORE_CONTROL_MASK = 8'h33;
    localparam logic [7:0] EXT_IRQ_MASK_MASK = 8'h40;
    localparam logic [7:0] TIMER_MASK_MASK = 8'h02;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Sense codes
    localparam logic [1:0] SENSE_LOW = 2'b00;
    localparam logic [1:0] SENSE_FALL = 2'b10;
    localparam logic [1:0] SENSE_RISE = 2'b11;

    // Vector program addresses
    localparam logic [8:0] EXT_VECTOR_ADDR = 9'h001;
    localparam logic [8:0] OVF_VECTOR_ADDR = 9'h002;

    // Entry and return each take four cycles
    localparam logic [1:0] SEQ_LAST = 2'd3;
    localparam int STACK_DEPTH = 3;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0]
    {
        ST_RUN = 3'b000,
        ST_ENTRY = 3'b001,
        ST_RETURN = 3'b010,
        ST_IDLE = 3'b011,
        ST_POWER_DOWN = 3'b100
    } core_state_t;

endpackage : irq_ctrl_pkg

/* File: test/core_model.sv */
// Core sequencer model: two-cycle instructions while not stalled.
// Assumes the controller's stall output halts instruction flow.
`timescale 1ns/1ns
module core_model
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic stall_in,
    output logic boundary_out
);
    logic phase_q;

    // Every instruction spans two cycles
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            phase_q <= 1'b0;
        else if (!stall_in)
            phase_q <= !phase_q;
    end

    // Boundary only at the end of a whole instruction
    assign boundary_out = phase_q && !stall_in;
endmodule : core_model

/* File: test/irq_ctrl_chk.sv */
// Concurrent checks on the interrupt and sleep controller's ports.
// Assumes binding into the controller top; sees only its ports.
`timescale 1ns/1ns
module irq_ctrl_chk
    import irq_ctrl_pkg::*;
#(
    parameter int PC_WIDTH = 9
)
(
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic RETURN_FROM_IRQ_IN,
    input wire logic INSTR_BOUNDARY_IN,
    input wire logic [PC_WIDTH-1:0] VECTOR_ADDR_OUT,
    input wire logic VECTOR_FETCH_OUT,
    input wire logic RETURN_LOAD_OUT,
    input wire logic CORE_STALL_OUT,
    input wire logic OSC_STOP_OUT,
    input wire logic GLOBAL_ENABLE_OUT
);
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    // Return walk: four stall cycles, then the popped address
    sequence return_walk;
        CORE_STALL_OUT [*4] ##1 RETURN_LOAD_OUT;
    endsequence

    a_fetch_after_stall: assert property (
        VECTOR_FETCH_OUT |-> $past(CORE_STALL_OUT, 4) && !CORE_STALL_OUT)
        else $error("Vector fetch without four stall cycles");
    a_fetch_one_cycle: assert property (
        VECTOR_FETCH_OUT |=> !VECTOR_FETCH_OUT)
        else $error("Vector fetch pulse too long");
    a_fetch_gie_low: assert property (
        VECTOR_FETCH_OUT |-> !GLOBAL_ENABLE_OUT)
        else $error("Global enable still set at vector fetch");
    a_vector_addr_legal: assert property (
        VECTOR_FETCH_OUT |-> VECTOR_ADDR_OUT == EXT_VECTOR_ADDR
            || VECTOR_ADDR_OUT == OVF_VECTOR_ADDR)
        else $error("Vector address not an interrupt vector");
    a_return_four: assert property (
        RETURN_FROM_IRQ_IN && !CORE_STALL_OUT |=> return_walk)
        else $error("Return did not take four stall cycles");
    a_return_sets_gie: assert property (
        RETURN_FROM_IRQ_IN && !CORE_STALL_OUT |-> ##[5:6] GLOBAL_ENABLE_OUT)
        else $error("Return did not set global enable");
    a_osc_stop_stall: assert property (
        OSC_STOP_OUT |-> CORE_STALL_OUT)
        else $error("Oscillator stopped while core runs");
    a_bvalid_holds: assert property (
        S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
        else $error("Write response dropped before ready");
    a_rdata_upper_zero: assert property (
        S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h000000)
        else $error("Read data upper bits not zero");
    sequence irq_exit;
        RETURN_LOAD_OUT && $rose(GLOBAL_ENABLE_OUT);
    endsequence
    a_first_instr_runs: assert property (
        irq_exit ##0 INSTR_BOUNDARY_IN |=> !CORE_STALL_OUT)
        else $error("Entry at first boundary after return");
    a_first_instr_ends: assert property (
        irq_exit ##0 !INSTR_BOUNDARY_IN ##1 INSTR_BOUNDARY_IN
            |=> !CORE_STALL_OUT)
        else $error("Entry before one instruction after return");
endmodule : irq_ctrl_chk

bind irq_sense_and_sleep_control irq_ctrl_chk #(.PC_WIDTH(PC_WIDTH)) chk
(
    .MCLK_IN(MCLK_IN),
    .RESET_N_IN(RESET_N_IN),
    .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
    .S_AXI_BREADY_IN(S_AXI_BREADY_IN),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT),
    .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
    .RETURN_FROM_IRQ_IN(RETURN_FROM_IRQ_IN),
    .INSTR_BOUNDARY_IN(INSTR_BOUNDARY_IN),
    .VECTOR_ADDR_OUT(VECTOR_ADDR_OUT),
    .VECTOR_FETCH_OUT(VECTOR_FETCH_OUT),
    .RETURN_LOAD_OUT(RETURN_LOAD_OUT),
    .CORE_STALL_OUT(CORE_STALL_OUT),
    .OSC_STOP_OUT(OSC_STOP_OUT),
    .GLOBAL_ENABLE_OUT(GLOBAL_ENABLE_OUT)
);

/* File: test/irq_sense_and_sleep_control_tb.sv */
// Self-checking bench for the interrupt and sleep controller.
// Assumes the core model in the core_model file and the bound checker.
`timescale 1ns/1ns
module irq_sense_and_sleep_control_tb;
    import irq_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, pin = 1'b1;
    logic [6:0] ctl = 7'h00; // sleep,return_from_irq,call,ret,set,clear,overflow
    logic [8:0] pc = 9'h000;
    logic [8:0] vaddr, raddr;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp, code;
    logic awready, wready, bvalid, arready, rvalid;
    logic fetch, load, stall, osc, gie, bnd;
    logic [7:0] addrs [6] = '{CORE_CONTROL_ADDR, EXT_IRQ_MASK_ADDR,
        TIMER_IRQ_MASK_ADDR, TIMER_IRQ_FLAGS_ADDR, STATUS_WORD_ADDR,
        CORE_STATE_ADDR};
    logic [7:0] masks [6] = '{CORE_CONTROL_MASK, EXT_IRQ_MASK_MASK,
        TIMER_MASK_MASK, 8'h00, 8'h80, 8'h00};
    logic [1:0] codes [3] = '{SENSE_FALL, SENSE_RISE, SENSE_LOW};
    int fail_count = 0;
    int cmp_count = 0;
    int fetches = 0;
    int n0;

    // Clock at 125 MHz
    always #4 clk = !clk;

    irq_sense_and_sleep_control uut
    (
        .MCLK_IN(clk),
        .RESET_N_IN(rst_n),
        .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWVALID_IN(awvalid),
        .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(4'hf),
        .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr),
        .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready),
        .INSTR_BOUNDARY_IN(bnd),
        .SLEEP_INSTR_IN(ctl[0]),
        .RETURN_FROM_IRQ_IN(ctl[1]),
        .CALL_IN(ctl[2]),
        .RET_IN(ctl[3]),
        .SET_GLOBAL_IN(ctl[4]),
        .CLEAR_GLOBAL_IN(ctl[5]),
        .PC_IN(pc),
        .VECTOR_ADDR_OUT(vaddr),
        .VECTOR_FETCH_OUT(fetch),
        .RETURN_ADDR_OUT(raddr),
        .RETURN_LOAD_OUT(load),
        .CORE_STALL_OUT(stall),
        .OSC_STOP_OUT(osc),
        .GLOBAL_ENABLE_OUT(gie),
        .EXTERNAL_REQUEST_LINE_IN(pin),
        .TIMER_OVERFLOW_IN(ctl[6])
    );

    core_model core
    (
        .clk_in(clk),
        .rst_n_in(rst_n),
        .stall_in(stall),
        .boundary_out(bnd)
    );

    // Count vector fetches where outputs are settled
    always @(negedge clk)
        if (fetch === 1'b1)
            fetches++;

    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        b = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b)
        begin
            @(negedge clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            r = bresp;
            @(posedge clk);
            if (aw)
                awvalid <= 1'b0;
            if (w)
                wvalid <= 1'b0;
            if (b)
                bready <= 1'b0;
        end
        check(r, er);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, b;
        logic [1:0] r;
        logic [31:0] d;
        b = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!b)
        begin
            @(negedge clk);
            ar = arvalid && arready;
            b = rvalid && rready;
            r = rresp;
            d = rdata;
            @(posedge clk);
            if (ar)
                arvalid <= 1'b0;
            if (b)
                rready <= 1'b0;
        end
        check(r, er);
        if (er == RESP_OKAY)
            check(d, ed);
    endtask : rd

    // One-cycle pulse on a core or timer event line
    task strobe(input int i);
        @(posedge clk);
        ctl[i] <= 1'b1;
        @(posedge clk);
        ctl[i] <= 1'b0;
    endtask : strobe

    // Bounded wait for a fetch or load pulse, then its address
    task wait_ev(input logic [8:0] ea, input bit ld);
        int n;
        n = 0;
        @(negedge clk);
        while ((ld ? load : fetch) !== 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        check(ld ? load : fetch, 1);
        check(ld ? raddr : vaddr, ea);
    endtask : wait_ev

    // Return from a handler and confirm enable comes back
    task leave;
        strobe(1);
        wait_ev(9'h055, 1);
        repeat (2) @(negedge clk);
        check(gie, 1);
    endtask : leave

    // Watchdog on the whole run
    initial
    begin
        #100000;
        fail_count++;
        report_and_stop;
    end

    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(addrs[i], 32'h0, RESP_OKAY);
        for (int i = 0; i < 6; i++)
        begin
            wr(addrs[i], 32'hffffffff, RESP_OKAY);
            rd(addrs[i], {24'h0, masks[i]}, RESP_OKAY);
            wr(addrs[i], 32'h0, RESP_OKAY);
        end
        wr(8'h3c, 32'h1, RESP_SLVERR);
        rd(8'h3c, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            pc <= 9'h010 + 9'(i);
            strobe(2);
        end
        for (int i = 0; i < 3; i++)
        begin
            strobe(3);
            wait_ev(9'h013 - 9'(i), 1);
        end
        @(posedge clk);
        pc <= 9'h055;
        for (int k = 0; k < 3; k++)
        begin
            code = codes[k];
            strobe(5);
            pin <= (code != SENSE_RISE);
            wr(EXT_IRQ_MASK_ADDR, 32'h0, RESP_OKAY);
            wr(CORE_CONTROL_ADDR, {30'h0, SENSE_LOW}, RESP_OKAY);
            wr(CORE_CONTROL_ADDR, {30'h0, code}, RESP_OKAY);
            wr(EXT_IRQ_MASK_ADDR, 32'h40, RESP_OKAY);
            strobe(4);
            n0 = fetches;
            repeat (10) @(posedge clk);
            check(fetches - n0, 0);
            pin <= !pin;
            wait_ev(EXT_VECTOR_ADDR, 0);
            check(gie, 0);
            @(posedge clk);
            pin <= (code != SENSE_RISE);
            leave;
        end
        strobe(5);
        wr(TIMER_IRQ_MASK_ADDR, 32'h2, RESP_OKAY);
        strobe(6);
        rd(TIMER_IRQ_FLAGS_ADDR, 32'h2, RESP_OKAY);
        wr(TIMER_IRQ_FLAGS_ADDR, 32'h2, RESP_OKAY);
        rd(TIMER_IRQ_FLAGS_ADDR, 32'h0, RESP_OKAY);
        strobe(6);
        @(posedge clk);
        pin <= 1'b0;
        strobe(4);
        wait_ev(EXT_VECTOR_ADDR, 0);
        @(posedge clk);
        pin <= 1'b1;
        leave;
        wait_ev(OVF_VECTOR_ADDR, 0);
        rd(TIMER_IRQ_FLAGS_ADDR, 32'h0, RESP_OKAY);
        leave;
        wr(CORE_CONTROL_ADDR, 32'h02, RESP_OKAY);
        strobe(0);
        repeat (3) @(negedge clk);
        check(stall, 0);
        wr(CORE_CONTROL_ADDR, 32'h22, RESP_OKAY);
        strobe(0);
        repeat (3) @(negedge clk);
        check({stall, osc}, 2'b10);
        strobe(6);
        wait_ev(OVF_VECTOR_ADDR, 0);
        leave;
        wr(CORE_CONTROL_ADDR, 32'h30, RESP_OKAY);
        strobe(0);
        repeat (3) @(negedge clk);
        check({stall, osc}, 2'b11);
        strobe(6);
        repeat (3) @(negedge clk);
        check(osc, 1);
        @(posedge clk);
        pin <= 1'b0;
        wait_ev(EXT_VECTOR_ADDR, 0);
        @(posedge clk);
        pin <= 1'b1;
        leave;
        report_and_stop;
    end
endmodule : irq_sense_and_sleep_control_tb
